//--- inc/dram_cmd_pkg.sv
// Package for the SDRAM command decoder and power-state controller.
// Assumes a single clock at 125 MHz; the three ns exit delays derive their counts from the period.
package dram_cmd_pkg;

   // ****************************************************************
   // Clock and timing
   // ****************************************************************
   localparam int CLK_PERIOD_PS = 8000;
   localparam int SELF_REFRESH_EXIT_DELAY_NS = 170;
   localparam int SELF_REFRESH_EXIT_DELAY_CYC =
      (SELF_REFRESH_EXIT_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int FAST_EXIT_DELAY_NS = 100;
   localparam int FAST_EXIT_DELAY_CYC =
      (FAST_EXIT_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int ABORT_EXIT_DELAY_NS = 120;
   localparam int ABORT_EXIT_DELAY_CYC =
      (ABORT_EXIT_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int EXIT_TO_LOCKED_DELAY_CYC = 768;
   localparam int BURST_LEN_8_CYC = 4;
   localparam int BURST_CHOP_4_CYC = 2;
   localparam int DLL_OFF_READ_LATENCY = 10;
   localparam int DLL_OFF_WRITE_LATENCY = 9;

   // ****************************************************************
   // Mode register fields
   // ****************************************************************
   localparam logic [2:0] MR0_SEL = 3'h0;
   localparam logic [2:0] MR1_SEL = 3'h1;
   localparam logic [2:0] MR4_SEL = 3'h4;
   localparam int MR1_DLL_ENABLE_BIT = 0;
   localparam int MR0_BURST_LSB = 0;
   localparam int MR4_SR_ABORT_BIT = 9;
   localparam logic [1:0] BURST_FIXED_BL8 = 2'h0;
   localparam logic [1:0] BURST_ON_THE_FLY = 2'h1;
   localparam logic [1:0] BURST_FIXED_BC4 = 2'h2;
   localparam int OTF_BL8_BIT = 12;
   localparam logic [17:0] MR0_RESET = 18'h00000;
   localparam logic [17:0] MR1_RESET = 18'h00001;
   localparam logic [17:0] MR4_RESET = 18'h00000;

   // ****************************************************************
   // Decoded commands and power states
   // ****************************************************************
   typedef enum {
      CMD_DESELECT, CMD_NOP, CMD_MODE_SET, CMD_REFRESH, CMD_PRECHARGE,
      CMD_ACTIVATE, CMD_WRITE, CMD_READ, CMD_ZQ_CAL, CMD_RESERVED
   } cmd_type;

   typedef enum {
      ST_IDLE, ST_ACTIVE, ST_PRECHARGE_PD, ST_ACTIVE_PD, ST_SELF_REFRESH
   } power_state_type;

endpackage

//--- src/dram_down_counter.sv
// Loadable down counter for one exit or burst delay.
// Assumes synchronous active-low reset and a load pulse from the owner.
`timescale 1ns/1ps
`default_nettype none
module dram_down_counter #(
   parameter int WIDTH = 10
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Control
   input  wire logic             load,
   input  wire logic [WIDTH-1:0] load_value,
   // Status
   output logic                  busy
);

   logic [WIDTH-1:0] count;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         count <= '0;
      end else if (load) begin
         count <= load_value;
      end else if (count != '0) begin
         count <= count - 1'b1;
      end
   end

   assign busy = (count != '0);

endmodule
`default_nettype wire

//--- src/dram_cmd_power_state_ctrl.sv
// Command decoder and power-state sequencer of the SDRAM device.
// Assumes pins are synchronous to clk; rst_n stands for the device reset.
`timescale 1ns/1ps
`default_nettype none
module dram_cmd_power_state_ctrl
   import dram_cmd_pkg::*;
#(
   parameter int BANKS = 8,
   parameter int REFRESH_COUNT_WIDTH = 13,
   parameter int EXIT_TO_LOCKED_DELAY = EXIT_TO_LOCKED_DELAY_CYC
) (
   // Clock and reset
   input  wire logic                           clk,
   input  wire logic                           rst_n,
   // Command pins
   input  wire logic                           chip_select_n,
   input  wire logic                           activate_n,
   input  wire logic                           row_strobe_n,
   input  wire logic                           column_strobe_n,
   input  wire logic                           write_enable_n,
   input  wire logic                           clock_enable,
   input  wire logic [1:0]                     bank_group,
   input  wire logic [1:0]                     bank_addr,
   input  wire logic [17:0]                    addr,
   // Power and mode status
   output logic                                power_down,
   output logic                                active_power_down,
   output logic                                self_refresh,
   output logic                                dll_enabled,
   output logic [3:0]                          read_strobe_delay,
   output logic                                latency_ok,
   output logic                                burst_active,
   output logic                                exit_busy,
   output logic                                locked_busy,
   output logic                                refresh_pulse,
   output logic [REFRESH_COUNT_WIDTH-1:0]      refresh_count,
   output logic [2:0]                          row_addr_high,
   output logic                                illegal_cmd
);

   // ****************************************************************
   // Command decode
   // ****************************************************************
   cmd_type         cmd;
   power_state_type state;
   logic            cke_prev;
   logic [BANKS-1:0] bank_open;
   logic [17:0]     mr0;
   logic [17:0]     mr1;
   logic [17:0]     mr4;
   logic            refresh_since_exit;
   logic            exit_load;
   logic            fast_busy;
   logic            burst_load;
   logic [2:0]      burst_cycles;
   logic [9:0]      exit_value;
   logic [3:0]      read_latency;
   logic [2:0]      bank_index;

   assign bank_index = {bank_group[0], bank_addr};

   always_comb begin
      cmd = CMD_RESERVED;
      if (chip_select_n) begin
         cmd = CMD_DESELECT;
      end else if (!activate_n) begin
         cmd = CMD_ACTIVATE;
      end else begin
         case ({row_strobe_n, column_strobe_n, write_enable_n})
            3'h0: cmd = CMD_MODE_SET;
            3'h1: cmd = CMD_REFRESH;
            3'h2: cmd = CMD_PRECHARGE;
            3'h3: cmd = CMD_RESERVED;
            3'h4: cmd = CMD_WRITE;
            3'h5: cmd = CMD_READ;
            3'h6: cmd = CMD_ZQ_CAL;
            3'h7: cmd = CMD_NOP;
            default: cmd = CMD_RESERVED;
         endcase
      end
   end

   // ****************************************************************
   // Clock-enable history and power states
   // ****************************************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cke_prev <= 1'b0;
      end else begin
         cke_prev <= clock_enable;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state <= ST_IDLE;
      end else begin
         case ({cke_prev, clock_enable})
            2'b00: state <= state;
            2'b01: begin
               if (cmd == CMD_DESELECT &&
                   (state == ST_PRECHARGE_PD || state == ST_ACTIVE_PD ||
                    state == ST_SELF_REFRESH)) begin
                  state <= (bank_open != '0) ? ST_ACTIVE : ST_IDLE;
               end
            end
            2'b10: begin
               if (cmd == CMD_REFRESH && state == ST_IDLE &&
                   bank_open == '0 && !burst_active && refresh_since_exit) begin
                  state <= ST_SELF_REFRESH;
               end else if (cmd == CMD_DESELECT || cmd == CMD_REFRESH) begin
                  state <= (bank_open == '0) ? ST_PRECHARGE_PD : ST_ACTIVE_PD;
               end
            end
            2'b11: begin
               if (state == ST_IDLE || state == ST_ACTIVE) begin
                  state <= (bank_open != '0) ? ST_ACTIVE : ST_IDLE;
               end
            end
            default: state <= state;
         endcase
      end
   end

   // ****************************************************************
   // Bank tracking and mode registers
   // ****************************************************************
   logic cmd_live;
   assign cmd_live = cke_prev && clock_enable &&
                     (state == ST_IDLE || state == ST_ACTIVE);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         bank_open <= '0;
      end else if (cmd_live && cmd == CMD_ACTIVATE) begin
         bank_open[bank_index] <= 1'b1;
      end else if (cmd_live && cmd == CMD_PRECHARGE) begin
         if (addr[10]) begin
            bank_open <= '0;
         end else begin
            bank_open[bank_index] <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mr0 <= MR0_RESET;
         mr1 <= MR1_RESET;
         mr4 <= MR4_RESET;
      end else if (cmd_live && cmd == CMD_MODE_SET) begin
         case ({bank_group[0], bank_addr})
            MR0_SEL: mr0 <= addr;
            MR1_SEL: begin
               if (state == ST_IDLE) begin
                  mr1 <= addr;
               end
            end
            MR4_SEL: mr4 <= addr;
            default: mr0 <= mr0;
         endcase
      end
   end

   // ****************************************************************
   // Burst timing
   // ****************************************************************
   always_comb begin
      burst_cycles = 3'(BURST_LEN_8_CYC);
      case (mr0[MR0_BURST_LSB +: 2])
         BURST_FIXED_BC4: burst_cycles = 3'(BURST_CHOP_4_CYC);
         BURST_ON_THE_FLY: burst_cycles = addr[OTF_BL8_BIT] ?
                                          3'(BURST_LEN_8_CYC) : 3'(BURST_CHOP_4_CYC);
         default: burst_cycles = 3'(BURST_LEN_8_CYC);
      endcase
   end

   assign burst_load = cmd_live && (cmd == CMD_READ || cmd == CMD_WRITE) &&
                       !burst_active;

   logic burst_busy;
   dram_down_counter #(.WIDTH(3)) u_burst (
      .clk       (clk),
      .rst_n     (rst_n),
      .load      (burst_load),
      .load_value(burst_cycles),
      .busy      (burst_busy)
   );

   // ****************************************************************
   // Self-refresh exit delays
   // ****************************************************************
   assign exit_load = (state == ST_SELF_REFRESH) && !cke_prev && clock_enable &&
                      cmd == CMD_DESELECT;
   assign exit_value = mr4[MR4_SR_ABORT_BIT] ? 10'(ABORT_EXIT_DELAY_CYC) :
                       10'(SELF_REFRESH_EXIT_DELAY_CYC);

   logic exit_cnt_busy;
   logic lock_cnt_busy;
   dram_down_counter #(.WIDTH(10)) u_exit (
      .clk       (clk),
      .rst_n     (rst_n),
      .load      (exit_load),
      .load_value(exit_value),
      .busy      (exit_cnt_busy)
   );
   dram_down_counter #(.WIDTH(10)) u_fast (
      .clk       (clk),
      .rst_n     (rst_n),
      .load      (exit_load),
      .load_value(10'(FAST_EXIT_DELAY_CYC)),
      .busy      (fast_busy)
   );
   dram_down_counter #(.WIDTH(12)) u_lock (
      .clk       (clk),
      .rst_n     (rst_n),
      .load      (exit_load),
      .load_value(12'(EXIT_TO_LOCKED_DELAY)),
      .busy      (lock_cnt_busy)
   );

   // ****************************************************************
   // Refresh and self-refresh bookkeeping
   // ****************************************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         refresh_pulse <= 1'b0;
         refresh_count <= '0;
      end else begin
         refresh_pulse <= 1'b0;
         if (exit_load && mr4[MR4_SR_ABORT_BIT]) begin
            refresh_count <= refresh_count;
         end else if ((cmd_live && cmd == CMD_REFRESH && clock_enable) ||
                      (state == ST_SELF_REFRESH && !clock_enable)) begin
            refresh_pulse <= 1'b1;
            refresh_count <= refresh_count + 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         refresh_since_exit <= 1'b1;
      end else if (cmd_live && cmd == CMD_REFRESH) begin
         refresh_since_exit <= 1'b1;
      end else if (exit_load) begin
         refresh_since_exit <= 1'b0;
      end
   end

   // ****************************************************************
   // Status outputs
   // ****************************************************************
   assign read_latency = 4'(DLL_OFF_READ_LATENCY);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         power_down        <= 1'b0;
         active_power_down <= 1'b0;
         self_refresh      <= 1'b0;
         dll_enabled       <= 1'b1;
         read_strobe_delay <= '0;
         latency_ok        <= 1'b1;
         burst_active      <= 1'b0;
         exit_busy         <= 1'b0;
         locked_busy       <= 1'b0;
         row_addr_high     <= '0;
         illegal_cmd       <= 1'b0;
      end else begin
         power_down        <= (state == ST_PRECHARGE_PD) || (state == ST_ACTIVE_PD);
         active_power_down <= (state == ST_ACTIVE_PD);
         self_refresh      <= (state == ST_SELF_REFRESH);
         dll_enabled       <= mr1[MR1_DLL_ENABLE_BIT];
         read_strobe_delay <= mr1[MR1_DLL_ENABLE_BIT] ? read_latency :
                              read_latency - 4'h1;
         latency_ok        <= mr1[MR1_DLL_ENABLE_BIT] ||
                              (mr0[6:4] == 3'(DLL_OFF_READ_LATENCY - 9) &&
                               DLL_OFF_WRITE_LATENCY == 9);
         burst_active      <= burst_busy || burst_load;
         exit_busy         <= exit_cnt_busy;
         locked_busy       <= lock_cnt_busy;
         if (!chip_select_n && !activate_n) begin
            row_addr_high <= {row_strobe_n, column_strobe_n, write_enable_n};
         end
         illegal_cmd       <= (exit_cnt_busy && cmd != CMD_DESELECT &&
                               !(fast_busy == 1'b0 && (cmd == CMD_ZQ_CAL ||
                                 cmd == CMD_MODE_SET))) ||
                              (cmd == CMD_NOP);
      end
   end

endmodule
`default_nettype wire

//--- sim/dram_cmd_chk.sv
// Assertion checker for the SDRAM command and power-state block.
// Assumes it is bound to the block and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module dram_cmd_chk (
   // Clock and pins
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       chip_select_n,
   input  wire logic       activate_n,
   input  wire logic       row_strobe_n,
   input  wire logic       column_strobe_n,
   input  wire logic       write_enable_n,
   input  wire logic       clock_enable,
   // Status
   input  wire logic       power_down,
   input  wire logic       self_refresh,
   input  wire logic       dll_enabled,
   input  wire logic [3:0] read_strobe_delay,
   input  wire logic       burst_active,
   input  wire logic       exit_busy,
   input  wire logic       refresh_pulse,
   input  wire logic [2:0] row_addr_high,
   input  wire logic       illegal_cmd
);
   // ****************************************************************
   // Run-length counters
   // ****************************************************************
   localparam int EXIT_LONG  = 22;
   localparam int EXIT_ABORT = 15;
   logic [3:0] pins;
   logic [7:0] exit_run;
   logic [7:0] burst_run;
   assign pins = {activate_n, row_strobe_n, column_strobe_n, write_enable_n};
   always_ff @(posedge clk) begin
      if (!rst_n || !exit_busy) begin
         exit_run <= 8'h00;
      end else begin
         exit_run <= exit_run + 8'h01;
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_n || !burst_active) begin
         burst_run <= 8'h00;
      end else begin
         burst_run <= burst_run + 8'h01;
      end
   end
   // ****************************************************************
   // Properties
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   chk_pd_entry: assert property (
      $past(clock_enable, 2) && $past(clock_enable) && !clock_enable && chip_select_n
      && !power_down && !self_refresh && !exit_busy |-> ##2 power_down)
      else $error("power-down not entered");
   chk_state_hold: assert property (
      !$past(clock_enable, 2) && !$past(clock_enable) && !clock_enable
      |=> $stable({power_down, self_refresh}))
      else $error("low-power state not held");
   chk_pd_exit: assert property (
      power_down && !$past(clock_enable) && clock_enable && chip_select_n |-> ##2 !power_down)
      else $error("power-down not left");
   chk_sr_entry: assert property (
      $past(clock_enable, 2) && $past(clock_enable) && !clock_enable && !chip_select_n
      && pins == 4'h9 && !power_down && !self_refresh && !exit_busy
      |-> ##2 (self_refresh != power_down))
      else $error("refresh with enable low gave no low-power state");
   chk_pd_no_refresh: assert property (
      power_down && $past(power_down) |-> !refresh_pulse)
      else $error("refresh during power-down");
   chk_exit_length: assert property (
      $fell(exit_busy) |-> exit_run == EXIT_LONG || exit_run == EXIT_ABORT)
      else $error("exit delay length wrong");
   chk_exit_illegal: assert property (
      exit_busy && clock_enable && !chip_select_n && pins == 4'hD ##1 exit_busy
      |-> ##[0:1] illegal_cmd)
      else $error("read during exit delay not flagged");
   chk_strobe_delay: assert property (
      $past(rst_n) && $stable(dll_enabled)
      |-> read_strobe_delay == (dll_enabled ? 4'hA : 4'h9))
      else $error("read strobe delay wrong");
   chk_burst_length: assert property (
      $fell(burst_active) |-> burst_run == 8'h05 || burst_run == 8'h03)
      else $error("burst length wrong");
   chk_row_capture: assert property (
      $past(clock_enable) && clock_enable && !chip_select_n && !activate_n && !power_down
      && !self_refresh && !exit_busy |-> ##2 row_addr_high == $past(pins[2:0], 2))
      else $error("row bits not captured");
endmodule
`default_nettype wire

//--- sim/dram_ctrl_model.sv
// Behavioural memory controller that drives the command pins.
// Assumes the bench sets a request just after each rising edge.
`timescale 1ns/1ps
`default_nettype none
module dram_ctrl_model
   import dram_cmd_pkg::*;
(
   // Requests
   input  wire logic        clk,
   input  var  cmd_type     op,
   input  wire logic        cke_req,
   input  wire logic [17:0] a,
   input  wire logic [3:0]  sel,
   // Command pins
   output logic             chip_select_n,
   output logic             activate_n,
   output logic             row_strobe_n,
   output logic             column_strobe_n,
   output logic             write_enable_n,
   output logic             clock_enable,
   output logic [1:0]       bank_group,
   output logic [1:0]       bank_addr,
   output logic [17:0]      addr
);
   // ****************************************************************
   // Pin encoding
   // ****************************************************************
   logic [4:0]  code;
   logic [25:0] bus;
   assign {activate_n, row_strobe_n, column_strobe_n, write_enable_n, bank_group,
           bank_addr, addr} = bus;
   always_comb begin
      case (op)
         CMD_MODE_SET:  code = 5'h08;
         CMD_REFRESH:   code = 5'h09;
         CMD_PRECHARGE: code = 5'h0A;
         CMD_ACTIVATE:  code = {2'b00, a[16:14]};
         CMD_WRITE:     code = 5'h0C;
         CMD_READ:      code = 5'h0D;
         CMD_ZQ_CAL:    code = 5'h0E;
         default:       code = 5'h10;
      endcase
   end
   initial begin
      bus = 26'h0000000;
      chip_select_n = 1'b1;
      clock_enable = 1'b0;
   end
   always @(negedge clk) begin
      clock_enable <= cke_req;
      chip_select_n <= code[4];
      if (code[4]) begin
         bus <= ~bus;
      end else begin
         bus <= {code[3:0], sel, a};
      end
   end
endmodule
`default_nettype wire

//--- sim/testbench.sv
// Self-checking bench for the SDRAM command and power-state block.
// Assumes the controller model drives the pins and the checker is bound.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import dram_cmd_pkg::*;
   // ****************************************************************
   // Signals and instances
   // ****************************************************************
   logic        clk, rst_n, chip_select_n, activate_n, row_strobe_n, column_strobe_n;
   logic        write_enable_n, clock_enable, power_down, active_power_down, self_refresh;
   logic        dll_enabled, latency_ok, burst_active, exit_busy, locked_busy, seen;
   logic        refresh_pulse, illegal_cmd, cke_req;
   logic [1:0]  bank_group, bank_addr;
   logic [2:0]  row_addr_high;
   logic [3:0]  read_strobe_delay, sel;
   logic [12:0] refresh_count, count_seen;
   logic [17:0] addr, a;
   cmd_type     op;
   int          n_mismatch, comparisons;
   dram_ctrl_model model (.*);
   dram_cmd_power_state_ctrl #(.EXIT_TO_LOCKED_DELAY(20)) dut (.*);
   // ****************************************************************
   // Tasks
   // ****************************************************************
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic cmd(input cmd_type o, input logic c, input logic [17:0] ad, input logic [3:0] s);
      @(posedge clk);
      op <= o;
      cke_req <= c;
      a <= ad;
      sel <= s;
   endtask
   task automatic cke(input logic c);
      cmd(CMD_DESELECT, c, 18'h00000, 4'h0);
   endtask
   task automatic idle(input int n);
      repeat (n) cke(cke_req);
      #1;
   endtask
   task automatic run_len(input logic w, input logic [15:0] len, input string what);
      int n;
      n = 0;
      #1;
      while ((w ? exit_busy : burst_active) !== 1'b1 && n < 8) begin
         @(posedge clk);
         #1;
         n++;
      end
      n = 0;
      while ((w ? exit_busy : burst_active) === 1'b1 && n < 400) begin
         n++;
         @(posedge clk);
         #1;
      end
      check(what, len, n[15:0]);
   endtask
   task automatic s_power_down();
      cke(1'b0);
      idle(4);
      check("power_down", 16'h1, power_down);
      check("active_power_down", 16'h0, active_power_down);
      count_seen = refresh_count;
      idle(6);
      check("refresh_count", {3'b000, count_seen}, {3'b000, refresh_count});
      check("power_down", 16'h1, power_down);
      cke(1'b1);
      idle(4);
      check("power_down", 16'h0, power_down);
      cmd(CMD_ACTIVATE, 1'b1, 18'h14000, 4'h0);
      idle(3);
      check("row_addr_high", 16'h5, row_addr_high);
      cke(1'b0);
      idle(4);
      check("active_power_down", 16'h1, active_power_down);
      cke(1'b1);
      idle(4);
      cmd(CMD_PRECHARGE, 1'b1, 18'h00400, 4'h0);
      idle(4);
   endtask
   task automatic s_burst(input cmd_type o, input logic [17:0] mode, input logic [17:0] ra,
                          input logic [15:0] len);
      cmd(CMD_MODE_SET, 1'b1, mode, 4'h0);
      idle(4);
      cmd(CMD_ACTIVATE, 1'b1, 18'h00000, 4'h0);
      idle(4);
      cmd(o, 1'b1, ra, 4'h0);
      idle(1);
      run_len(1'b0, len, "burst_active");
      cmd(CMD_PRECHARGE, 1'b1, 18'h00400, 4'h0);
      idle(4);
   endtask
   task automatic s_dll();
      cmd(CMD_MODE_SET, 1'b1, 18'h00000, 4'h1);
      idle(4);
      check("dll_enabled", 16'h0, dll_enabled);
      check("read_strobe_delay", 16'h9, read_strobe_delay);
      check("latency_ok", 16'h0, latency_ok);
      cmd(CMD_MODE_SET, 1'b1, 18'h00010, 4'h0);
      idle(4);
      check("latency_ok", 16'h1, latency_ok);
      cmd(CMD_MODE_SET, 1'b1, 18'h00001, 4'h1);
      idle(4);
      check("read_strobe_delay", 16'hA, read_strobe_delay);
   endtask
   task automatic s_self_refresh(input logic [17:0] mr4, input logic [15:0] len, input logic probe);
      cmd(CMD_MODE_SET, 1'b1, mr4, 4'h4);
      idle(4);
      cmd(CMD_REFRESH, 1'b1, 18'h00000, 4'h0);
      idle(8);
      cmd(CMD_REFRESH, 1'b0, 18'h00000, 4'h0);
      cke(1'b0);
      idle(6);
      check("self_refresh", 16'h1, self_refresh);
      check("power_down", 16'h0, power_down);
      cke(1'b1);
      if (probe) begin
         idle(3);
         cmd(CMD_READ, 1'b1, 18'h00000, 4'h0);
         seen = 1'b0;
         repeat (4) begin
            cke(1'b1);
            #1;
            seen = seen | illegal_cmd;
         end
         check("illegal_cmd", 16'h1, seen);
         check("locked_busy", 16'h1, locked_busy);
         idle(5);
         cmd(CMD_ZQ_CAL, 1'b1, 18'h00000, 4'h0);
         cke(1'b1);
         #1;
         check("illegal_cmd", 16'h0, illegal_cmd);
         check("locked_busy", 16'h1, locked_busy);
         idle(30);
         check("locked_busy", 16'h0, locked_busy);
      end else begin
         run_len(1'b1, len, "exit_busy");
      end
   endtask
   task automatic close_out();
      $display("Mismatches %0d in %0d comparisons", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // ****************************************************************
   // Sequence
   // ****************************************************************
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      repeat (4000) @(posedge clk);
      n_mismatch++;
      close_out();
   end
   initial begin
      {rst_n, cke_req, a, sel, n_mismatch, comparisons} = '0;
      op = CMD_DESELECT;
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      idle(1);
      check("dll_enabled", 16'h1, dll_enabled);
      check("read_strobe_delay", 16'hA, read_strobe_delay);
      check("self_refresh", 16'h0, self_refresh);
      cke(1'b1);
      idle(4);
      s_power_down();
      s_burst(CMD_READ, 18'h00002, 18'h00000, 16'h3);
      s_burst(CMD_READ, 18'h00000, 18'h00000, 16'h5);
      s_burst(CMD_WRITE, 18'h00001, 18'h01000, 16'h5);
      s_burst(CMD_READ, 18'h00001, 18'h00000, 16'h3);
      s_dll();
      s_self_refresh(18'h00000, 16'd22, 1'b0);
      cmd(CMD_REFRESH, 1'b0, 18'h00000, 4'h0);
      cke(1'b0);
      idle(6);
      check("self_refresh", 16'h0, self_refresh);
      check("power_down", 16'h1, power_down);
      cke(1'b1);
      idle(4);
      s_self_refresh(18'h00200, 16'd15, 1'b0);
      s_self_refresh(18'h00200, 16'd15, 1'b1);
      close_out();
   end
endmodule
bind dram_cmd_power_state_ctrl dram_cmd_chk chk (.*);
`default_nettype wire
